// *** wdog_pkg.sv ***
// package: watchdog guard register map, field layout, fuse levels and timing constants
`default_nettype none
package wdog_pkg;
	// apb register map (byte addresses)
	localparam logic [7:0]  ctrl_addr      = 8'h00;
	localparam logic [7:0]  status_addr    = 8'h04;
	localparam logic [7:0]  restart_addr   = 8'h08;
	// control register fields
	localparam int          timeout_select_lsb = 0;
	localparam int          timeout_select_msb = 2;
	localparam int          wdog_enable_pos = 3;
	localparam int          change_enable_pos = 4;
	localparam logic [2:0]  timeout_select_reset = 3'h0;
	// restart key written to the restart register
	localparam logic [31:0] restart_key    = 32'h0000_00a5;
	// change-enable window, in system clock cycles
	localparam logic [2:0]  ce_window      = 3'h4;
	// shortest period in watchdog oscillator cycles (16k), doubling per code step
	localparam int          base_period_lg = 14;
	localparam int          cnt_w          = 22;
	// fuse-derived safety levels
	typedef enum logic [1:0] {
		level0 = 2'h0,
		level1 = 2'h1,
		level2 = 2'h2
	} level_t;
	// apb request carrier
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;
endpackage : wdog_pkg
`default_nettype wire

// *** wdog_counter.sv ***
// watchdog period counter on the watchdog oscillator tick
`timescale 1ns/1ps
`default_nettype none
module wdog_counter (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// control
	input  wire logic       run,
	input  wire logic       restart,
	input  wire logic       tick,
	input  wire logic [2:0] sel,
	// result
	output logic            expired
);
	typedef struct packed {
		logic [wdog_pkg::cnt_w-1:0] cnt;
		logic                       expired;
	} cstate_t;

	cstate_t s_r;
	cstate_t s_nxt;
	logic [wdog_pkg::cnt_w-1:0] limit;

	// period is 2^(14+sel) oscillator cycles
	assign limit = wdog_pkg::cnt_w'((23'h1 << (wdog_pkg::base_period_lg + int'(sel))) - 23'h1);

	always_comb begin
		s_nxt = s_r;
		s_nxt.expired = 1'b0;
		if (!run || restart) begin
			s_nxt.cnt = '0;
		end else if (tick) begin
			if (s_r.cnt >= limit) begin
				s_nxt.expired = 1'b1;
				s_nxt.cnt = '0;
			end else begin
				s_nxt.cnt = s_r.cnt + {{(wdog_pkg::cnt_w-1){1'b0}}, 1'b1};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign expired = s_r.expired;
endmodule : wdog_counter
`default_nettype wire

// *** wdog_guard.sv ***
// watchdog configuration guard with apb control register and timeout counter
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module wdog_guard (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// fuses, high when programmed
	input  wire logic        compat_level_fuse,
	input  wire logic        always_on_fuse,
	// watchdog oscillator tick from another domain
	input  wire logic        wdog_osc_tick,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// status
	output logic             wdog_running,
	output logic             chip_reset_req
);
	typedef struct packed {
		logic [1:0]  level;
		logic        fuses_taken;
		logic        wdog_enable_bit;
		logic        change_enable_bit;
		logic [2:0]  ce_cnt;
		logic [2:0]  timeout_select;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        restart;
		logic        running;
		logic        rst_req;
		logic [2:0]  tick_sync;
	} state_t;

	state_t               s_r;
	state_t               s_nxt;
	wdog_pkg::apb_req_t   req;
	wdog_pkg::level_t     lvl;
	logic                 expired;
	logic                 tick;
	logic                 wr;
	logic                 rd;
	logic                 open_wr;
	logic                 win_open;
	logic                 ctrl_wr;
	logic                 open_taken;
	logic                 en_wr;
	logic [2:0]           sel_wr;
	logic [7:0]           ctrl_val;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
	assign lvl = wdog_pkg::level_t'(s_r.level);
	assign wr = req.psel && req.penable && req.pwrite && !s_r.pready;
	assign rd = req.psel && req.penable && !req.pwrite && !s_r.pready;
	assign win_open = s_r.change_enable_bit;
	assign ctrl_wr = wr && req.paddr == wdog_pkg::ctrl_addr;
	assign en_wr = req.pwdata[wdog_pkg::wdog_enable_pos];
	assign sel_wr = req.pwdata[wdog_pkg::timeout_select_msb:wdog_pkg::timeout_select_lsb];
	assign open_wr = req.pwdata[wdog_pkg::change_enable_pos] && en_wr;
	assign open_taken = ctrl_wr && open_wr;
	// rising edge of the synchronised oscillator tick, second stage onward only
	assign tick = s_r.tick_sync[1] && !s_r.tick_sync[2];
	// enable reads one in level 2
	assign ctrl_val = {3'h0, s_r.change_enable_bit,
		(s_r.wdog_enable_bit || lvl == wdog_pkg::level2), s_r.timeout_select};

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_nxt = s_r;
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;
		s_nxt.restart = 1'b0;
		s_nxt.tick_sync = {s_r.tick_sync[1:0], wdog_osc_tick};
		// fuses captured on the first clock after reset release
		if (!s_r.fuses_taken) begin
			s_nxt.fuses_taken = 1'b1;
			if (always_on_fuse) begin
				s_nxt.level = wdog_pkg::level2;
			end else if (compat_level_fuse) begin
				s_nxt.level = wdog_pkg::level0;
			end else begin
				s_nxt.level = wdog_pkg::level1;
			end
		end
		// change-enable window countdown
		if (s_r.change_enable_bit) begin
			if (s_r.ce_cnt == 3'h1) begin
				s_nxt.change_enable_bit = 1'b0;
			end
			s_nxt.ce_cnt = s_r.ce_cnt - 3'h1;
		end
		if (rd || wr) begin
			s_nxt.pready = 1'b1;
			s_nxt.prdata = '0;
		end
		if (rd) begin
			case (req.paddr)
				wdog_pkg::ctrl_addr:    s_nxt.prdata = {24'h0, ctrl_val};
				wdog_pkg::status_addr:  s_nxt.prdata = {29'h0, s_r.level, s_r.running};
				wdog_pkg::restart_addr: s_nxt.prdata = '0;
				default:                s_nxt.pslverr = 1'b1;
			endcase
		end
		if (wr) begin
			case (req.paddr)
				wdog_pkg::ctrl_addr: begin
					if (open_wr) begin
						// opening write: start window, enable stays or turns on
						s_nxt.change_enable_bit = 1'b1;
						s_nxt.ce_cnt = wdog_pkg::ce_window;
						s_nxt.wdog_enable_bit = 1'b1;
						if (lvl == wdog_pkg::level0) begin
							s_nxt.timeout_select = sel_wr;
						end
					end else if (win_open && !req.pwdata[wdog_pkg::change_enable_pos]) begin
						// committing write inside the window
						s_nxt.change_enable_bit = 1'b0;
						s_nxt.ce_cnt = '0;
						s_nxt.timeout_select = sel_wr;
						if (lvl != wdog_pkg::level2) begin
							s_nxt.wdog_enable_bit = en_wr;
						end
					end else begin
						if (en_wr) begin
							s_nxt.wdog_enable_bit = 1'b1;
						end
						// levels 1 and 2 keep the timeout select here
						if (lvl == wdog_pkg::level0) begin
							s_nxt.timeout_select = sel_wr;
						end
					end
				end
				wdog_pkg::status_addr: ;
				wdog_pkg::restart_addr: begin
					if (req.pwdata == wdog_pkg::restart_key) begin
						s_nxt.restart = 1'b1;
					end
				end
				default: s_nxt.pslverr = 1'b1;
			endcase
		end
		s_nxt.running = s_r.fuses_taken
			&& (s_nxt.wdog_enable_bit || lvl == wdog_pkg::level2);
		s_nxt.rst_req = expired;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	wdog_counter u_counter (
		.clk     (clk),
		.reset   (reset),
		.run     (s_r.running),
		.restart (s_r.restart),
		.tick    (tick),
		.sel     (s_r.timeout_select),
		.expired (expired)
	);

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign wdog_running = s_r.running;
	assign chip_reset_req = s_r.rst_req;

	////////////////////////////////////////////////////////////////////////////////
	// a commit may close the window early, a new opening write restarts it
	ce_window_a: assert property (@(posedge clk) disable iff (reset)
		open_taken ##1 !open_taken [*4] |=> !s_r.change_enable_bit)
		else $error("change enable did not clear after four cycles");
	window_open_a: assert property (@(posedge clk) disable iff (reset)
		open_taken |=> s_r.change_enable_bit)
		else $error("opening write did not open the window");
	lvl2_on_a: assert property (@(posedge clk) disable iff (reset)
		(s_r.fuses_taken && lvl == wdog_pkg::level2) |-> ##1 wdog_running)
		else $error("level 2 watchdog not running");
	closed_select_a: assert property (@(posedge clk) disable iff (reset)
		(ctrl_wr && !win_open && !open_wr && lvl != wdog_pkg::level0)
		|=> $stable(s_r.timeout_select))
		else $error("timeout select changed outside window");
	no_disable_a: assert property (@(posedge clk) disable iff (reset)
		(!win_open && !(wr && open_wr) && s_r.wdog_enable_bit) |=> s_r.wdog_enable_bit)
		else $error("watchdog disabled without timed sequence");
	enable_free_a: assert property (@(posedge clk) disable iff (reset)
		(ctrl_wr && en_wr) |=> s_r.wdog_enable_bit)
		else $error("enable write not taken");
	commit_apply_a: assert property (@(posedge clk) disable iff (reset)
		(ctrl_wr && win_open && !req.pwdata[wdog_pkg::change_enable_pos])
		|=> (s_r.timeout_select == $past(sel_wr) && !s_r.change_enable_bit))
		else $error("committing write not applied");
	lvl0_select_a: assert property (@(posedge clk) disable iff (reset)
		(ctrl_wr && lvl == wdog_pkg::level0) |=> s_r.timeout_select == $past(sel_wr))
		else $error("level 0 timeout write lost");
	expire_rst_a: assert property (@(posedge clk) disable iff (reset)
		expired |=> chip_reset_req)
		else $error("expiry did not request chip reset");
	apb_ready_a: assert property (@(posedge clk) disable iff (reset)
		(psel && penable) |-> ##[0:1] pready)
		else $error("apb access not answered");

	commit_c: cover property (@(posedge clk) disable iff (reset)
		win_open && ctrl_wr && !req.pwdata[wdog_pkg::change_enable_pos]);
	expire_c: cover property (@(posedge clk) disable iff (reset) chip_reset_req);
	timeout_c: cover property (@(posedge clk) disable iff (reset)
		$fell(s_r.change_enable_bit) && !wr);
endmodule : wdog_guard
`default_nettype wire

// *** wdog_guard_test.sv ***
// testbench: watchdog guard safety levels, timed unlock window and expiry
`timescale 1ns/1ps
`default_nettype none
module wdog_guard_test;
	logic        clk = 1'b0, reset = 1'b1, cf = 1'b0, af = 1'b0, tick = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        pready, pslverr, run, rreq, perr, seen = 1'b0, ton = 1'b0;
	logic [2:0]  w1, w2;
	int          err_total = 0, cmp_count = 0, ticks = 0, hit = 0, t0, lv;
	localparam logic [7:0] ca = wdog_pkg::ctrl_addr;

	always #5 clk = ~clk;

	wdog_guard u_wdog_guard (
		.clk(clk), .reset(reset), .compat_level_fuse(cf), .always_on_fuse(af),
		.wdog_osc_tick(tick), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .wdog_running(run), .chip_reset_req(rreq)
	);

	// fast oscillator ticks; records the tick count at the first expiry pulse
	always @(posedge clk) begin
		if (ton) tick <= ~tick;
		if (ton && !tick) ticks <= ticks + 1;
		if (rreq === 1'b1 && !seen) begin
			seen <= 1'b1;
			hit  <= ticks;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask : chk

	// chain keeps psel high so the next setup follows at once
	task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d, input bit chain);
		int n;
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
			wrap_up();
		end
		q       = prdata;
		perr    = pslverr;
		penable <= 1'b0;
		if (!chain) begin
			psel <= 1'b0;
			@(posedge clk);
		end
	endtask : apb

	task automatic rst(input logic c, input logic a);
		reset <= 1'b1;
		cf    <= c;
		af    <= a;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : rst

	function automatic logic [31:0] cx(input int l, input logic e, input logic [2:0] p);
		return {27'h0, 1'b0, e | (l == 2), p};
	endfunction : cx

	////////////////////////////////////////////////////////////////////////////
	task automatic lv_run(input logic c, input logic a);
		rst(c, a);
		lv = a ? 2 : (c ? 0 : 1);
		w1 = 3'(32'h1 + ($urandom() % 32'h7));
		w2 = 3'($urandom());
		apb(0, ca, 32'h0, 0);
		chk("ctrl reset", cx(lv, 1'b0, 3'h0), q);
		apb(0, wdog_pkg::status_addr, 32'h0, 0);
		chk("status", {29'h0, 2'(lv), lv == 2}, q);
		apb(1, ca, 32'h08, 0);
		apb(0, ca, 32'h0, 0);
		chk("plain enable", cx(lv, 1'b1, 3'h0), q);
		apb(1, ca, {29'h0, w1}, 0);
		apb(0, ca, 32'h0, 0);
		chk("unlocked write", cx(lv, 1'b1, lv == 0 ? w1 : 3'h0), q);
		apb(1, ca, 32'h18, 1);
		apb(1, ca, {29'h0, w2}, 0);
		apb(0, ca, 32'h0, 0);
		chk("timed commit", cx(lv, 1'b0, w2), q);
		chk("running", lv == 2, run);
		apb(1, ca, {24'h0, 5'h03, w2}, 0);
		repeat (6) @(posedge clk);
		apb(0, ca, 32'h0, 0);
		chk("window closed", cx(lv, 1'b1, w2), q);
		apb(1, ca, {24'h0, 5'h01, ~w2}, 0);
		apb(0, ca, 32'h0, 0);
		chk("late commit", cx(lv, 1'b1, lv == 0 ? ~w2 : w2), q);
		apb(0, 8'h0c, 32'h0, 0);
		chk("unmapped error", 32'h1, perr);
	endtask : lv_run

	initial begin
		void'($urandom(59099));
		lv_run(1'b1, 1'b0);
		lv_run(1'b0, 1'b0);
		lv_run(1'b0, 1'b1);
		lv_run(1'b1, 1'b1);
		rst(1'b0, 1'b1);
		ton <= 1'b1;
		for (int i = 0; i < 20000 && ticks < 8000; i++) @(posedge clk);
		apb(1, wdog_pkg::restart_addr, wdog_pkg::restart_key, 0);
		t0 = ticks;
		for (int i = 0; i < 40000 && !seen; i++) @(posedge clk);
		chk("expiry after restart", 32'h1, seen && hit - t0 >= 16380 && hit - t0 <= 16390);
		wrap_up();
	end
endmodule : wdog_guard_test
`default_nettype wire
